// ===== src/vioc_pkg.sv
// Constants shared by the vehicle I/O command logic.
// Assumes a 125 MHz clock and a 32-bit AXI4-Lite register bus.
package vioc_pkg;
  // Register byte offsets
  localparam logic [7:0] VIOC_CMD_OFF = 8'h00;
  localparam logic [7:0] VIOC_RESULT_OFF = 8'h04;
  localparam logic [7:0] VIOC_CFG_OFF = 8'h08;
  localparam logic [7:0] VIOC_STATUS_OFF = 8'h0C;
  localparam logic [7:0] VIOC_POTARG_OFF = 8'h10;
  localparam logic [7:0] VIOC_SUBARG_OFF = 8'h14;
  localparam logic [7:0] VIOC_THRLIM_OFF = 8'h18;
  localparam logic [7:0] VIOC_BRKLIM_OFF = 8'h1C;
  localparam logic [7:0] VIOC_SUBST_OFF = 8'h20;
  // Command opcodes, written to CMD[3:0]; selector in CMD[7:4]
  localparam logic [3:0] OP_PRE_START = 4'h1;
  localparam logic [3:0] OP_PRE_ABORT = 4'h2;
  localparam logic [3:0] OP_AUX_ON = 4'h3;
  localparam logic [3:0] OP_AUX_OFF = 4'h4;
  localparam logic [3:0] OP_REV_ON = 4'h5;
  localparam logic [3:0] OP_REV_OFF = 4'h6;
  localparam logic [3:0] OP_LOCK_SET = 4'h7;
  localparam logic [3:0] OP_LOCK_CLR = 4'h8;
  localparam logic [3:0] OP_POT_SETUP = 4'h9;
  localparam logic [3:0] OP_PUMP_ON = 4'hA;
  localparam logic [3:0] OP_PUMP_OFF = 4'hB;
  // Error codes returned in RESULT[15:8]
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] INVALID_SELECTOR_ERR = 8'h01;
  localparam logic [7:0] PARAM_RANGE_ERR = 8'h02;
  // Precharge phase codes
  localparam logic [2:0] PRE_NOT_DONE = 3'h0;
  localparam logic [2:0] PRE_BUSY = 3'h1;
  localparam logic [2:0] PRE_PASSED = 3'h2;
  localparam logic [2:0] PRE_ABORTED = 3'h3;
  localparam logic [2:0] PRE_ENERGY = 3'h4;
  localparam logic [2:0] PRE_TIMEOUT = 3'h5;
  // Source setting meaning program control
  localparam logic [1:0] SRC_PROG = 2'h1;
  // Pot scaling and limits
  localparam int POT_CPV = 64;
  localparam logic [8:0] POT_MAX = 9'h190;
  localparam int POT_LOW_MV = 100;
  localparam int POT_HIGH_MV = 5500;
  localparam logic [8:0] POT_LOW_DEF = 9'(POT_LOW_MV * POT_CPV / 1000);
  localparam logic [8:0] POT_HIGH_DEF = 9'(POT_HIGH_MV * POT_CPV / 1000);
  localparam logic [2:0] TYPE_NO_LOW = 3'h2;
  localparam logic [2:0] TYPE_SETUP = 3'h5;
  // Precharge time limit
  localparam int PRE_LIMIT_MS = 1000;
  localparam int CLK_KHZ = 125000;
  localparam int PRE_LIMIT_CYC = PRE_LIMIT_MS * CLK_KHZ;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== src/vioc_top.sv
// Vehicle I/O command logic: decodes software commands for precharge,
// two open-drain aux outputs, rescue reverse, safety lock, pot faults
// and the pump lift contactor. Assumes one 125 MHz clock, synchronous
// pin inputs and an external comparator that flags cap near supply.
module vioc_top #(
  parameter int PRE_LIMIT = vioc_pkg::PRE_LIMIT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cap_near_supply,
  input wire logic resistor_energy_over,
  output logic precharge_drive,
  input wire logic [1:0] aux_overcurrent,
  output logic [1:0] aux_out_o,
  output logic [1:0] aux_out_oe,
  output logic rescue_reverse_state,
  output logic motor_resume,
  output logic startup_check_req,
  output logic main_close_req,
  input wire logic [8:0] throttle_wiper,
  input wire logic [14:0] throttle_value,
  input wire logic [8:0] brake_wiper,
  input wire logic [14:0] brake_value,
  output logic [14:0] throttle_out,
  output logic [14:0] brake_out,
  output logic [1:0] pot_fault,
  output logic lift_driver
);
  import vioc_pkg::*;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic is_prog(input logic [1:0] src);
    return src == SRC_PROG;
  endfunction

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff;
  logic [3:0] wstrb_ff;
  logic [7:0] waddr_ff;
  logic [31:0] cfg_ff, potarg_ff, subarg_ff;
  logic res_ok_ff;
  logic [7:0] res_err_ff;
  logic [2:0] phase_ff;
  logic [26:0] pre_cnt_ff;
  logic pre_drive_ff;
  logic [1:0] aux_on_ff, aux_fault_ff, aux_o_ff;
  logic rev_ff, resume_ff, check_ff, lock_ff, main_ff, lift_ff;
  logic [8:0] lo_ff [2];
  logic [8:0] hi_ff [2];
  logic [14:0] sub_ff [2];
  logic [1:0] setup_ff, pfault_ff;
  logic [14:0] pout_ff [2];
  logic do_wr, cmd_fire, wr_ok;
  logic [3:0] op;
  logic [3:0] sel;
  logic sel_ok, rng_ok;
  logic nxt_ok;
  logic [7:0] nxt_err;
  logic [8:0] wiper [2];
  logic [14:0] pval [2];
  logic [2:0] ptype [2];
  logic [1:0] onewire;

  // Config fields
  wire [1:0] rev_source = cfg_ff[1:0];
  wire [1:0] lock_source = cfg_ff[3:2];
  wire lift_contactor_allow = cfg_ff[4];
  wire main_enable = cfg_ff[5];
  wire startup_sequence_check = cfg_ff[6];

  assign wiper[0] = throttle_wiper;
  assign wiper[1] = brake_wiper;
  assign pval[0] = throttle_value;
  assign pval[1] = brake_value;
  assign ptype[0] = cfg_ff[10:8];
  assign ptype[1] = cfg_ff[14:12];
  assign onewire = {cfg_ff[15], cfg_ff[11]};

  // Bus write path: address and data may arrive in either order
  assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_ok = (waddr_ff == VIOC_CMD_OFF) || (waddr_ff == VIOC_CFG_OFF)
    || (waddr_ff == VIOC_POTARG_OFF) || (waddr_ff == VIOC_SUBARG_OFF);
  assign cmd_fire = do_wr && (waddr_ff == VIOC_CMD_OFF);
  assign op = wdata_ff[3:0];
  assign sel = wdata_ff[7:4];
  assign sel_ok = sel < 4'h2;
  assign rng_ok = (potarg_ff[8:0] <= POT_MAX) && (potarg_ff[24:16] <= POT_MAX);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_ff)
      begin
        awready_ff <= 1'b0;
        waddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && wready_ff)
      begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Software-written holding registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_ff <= 32'h00000000;
      potarg_ff <= 32'h00000000;
      subarg_ff <= 32'h00000000;
    end
    else if (do_wr)
    begin
      if (waddr_ff == VIOC_CFG_OFF)
        cfg_ff <= wmerge(cfg_ff, wdata_ff, wstrb_ff);
      if (waddr_ff == VIOC_POTARG_OFF)
        potarg_ff <= wmerge(potarg_ff, wdata_ff, wstrb_ff);
      if (waddr_ff == VIOC_SUBARG_OFF)
        subarg_ff <= wmerge(subarg_ff, wdata_ff, wstrb_ff);
    end
  end

  // Bus read path; rdata is registered so the answer comes one cycle after ar
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        VIOC_RESULT_OFF: rdata_ff <= {16'h0000, res_err_ff, 7'h00, res_ok_ff};
        VIOC_CFG_OFF: rdata_ff <= cfg_ff;
        VIOC_STATUS_OFF: rdata_ff <= {18'h00000, lift_ff, main_ff, lock_ff, rev_ff, pfault_ff,
          aux_fault_ff, aux_on_ff, pre_drive_ff, phase_ff};
        VIOC_POTARG_OFF: rdata_ff <= potarg_ff;
        VIOC_SUBARG_OFF: rdata_ff <= subarg_ff;
        VIOC_THRLIM_OFF: rdata_ff <= {7'h00, hi_ff[0], 7'h00, lo_ff[0]};
        VIOC_BRKLIM_OFF: rdata_ff <= {7'h00, hi_ff[1], 7'h00, lo_ff[1]};
        VIOC_SUBST_OFF: rdata_ff <= {1'b0, sub_ff[1], 1'b0, sub_ff[0]};
        VIOC_CMD_OFF: rdata_ff <= 32'h00000000;
        default:
        begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Return value and error code of each command
  always_comb
  begin
    nxt_ok = 1'b1;
    nxt_err = ERR_NONE;
    case (op)
      OP_PRE_START, OP_PRE_ABORT: nxt_ok = 1'b1;
      OP_AUX_ON, OP_AUX_OFF:
      begin
        nxt_ok = sel_ok;
        nxt_err = sel_ok ? ERR_NONE : INVALID_SELECTOR_ERR;
      end
      OP_REV_ON, OP_REV_OFF: nxt_ok = is_prog(rev_source);
      OP_LOCK_SET, OP_LOCK_CLR: nxt_ok = is_prog(lock_source);
      OP_POT_SETUP:
      begin
        nxt_ok = sel_ok && rng_ok;
        nxt_err = !sel_ok ? INVALID_SELECTOR_ERR : (!rng_ok ? PARAM_RANGE_ERR : ERR_NONE);
      end
      OP_PUMP_ON, OP_PUMP_OFF: nxt_ok = lift_contactor_allow;
      default: nxt_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_ok_ff <= 1'b0;
      res_err_ff <= ERR_NONE;
    end
    else if (cmd_fire)
    begin
      res_ok_ff <= nxt_ok;
      res_err_ff <= nxt_err;
    end
  end

  // Precharge sequencer; a fault phase stays latched until abort or restart
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_ff <= PRE_NOT_DONE;
      pre_cnt_ff <= 27'h0000000;
      pre_drive_ff <= 1'b0;
    end
    else if (cmd_fire && op == OP_PRE_ABORT)
    begin
      phase_ff <= PRE_ABORTED;
      pre_drive_ff <= 1'b0;
    end
    else if (cmd_fire && op == OP_PRE_START)
    begin
      phase_ff <= PRE_BUSY;
      pre_cnt_ff <= 27'h0000000;
      pre_drive_ff <= 1'b1;
    end
    else if (phase_ff == PRE_BUSY)
    begin
      pre_cnt_ff <= pre_cnt_ff + 27'h0000001;
      // Energy limit checked first: it protects the resistor itself
      if (resistor_energy_over)
      begin
        phase_ff <= PRE_ENERGY;
        pre_drive_ff <= 1'b0;
      end
      else if (cap_near_supply)
      begin
        phase_ff <= PRE_PASSED;
        pre_drive_ff <= 1'b0;
      end
      else if (pre_cnt_ff >= 27'(PRE_LIMIT - 1))
      begin
        phase_ff <= PRE_TIMEOUT;
        pre_drive_ff <= 1'b0;
      end
    end
  end

  // Two open-drain aux drivers; while a driver is on, overcurrent beats a same-cycle on command
  for (genvar g = 0; g < 2; g++)
  begin : g_aux
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        aux_on_ff[g] <= 1'b0;
        aux_fault_ff[g] <= 1'b0;
        aux_o_ff[g] <= 1'b0;
      end
      else
      begin
        aux_o_ff[g] <= 1'b0;
        if (aux_overcurrent[g] && aux_on_ff[g])
        begin
          aux_fault_ff[g] <= 1'b1;
          aux_on_ff[g] <= 1'b0;
        end
        else if (cmd_fire && sel == 4'(g) && op == OP_AUX_ON)
        begin
          aux_on_ff[g] <= 1'b1;
          aux_fault_ff[g] <= 1'b0;
        end
        else if (cmd_fire && sel == 4'(g) && op == OP_AUX_OFF)
          aux_on_ff[g] <= 1'b0;
      end
    end
  end

  // Rescue reverse; resume and startup check are one-cycle pulses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rev_ff <= 1'b0;
      resume_ff <= 1'b0;
      check_ff <= 1'b0;
    end
    else
    begin
      resume_ff <= 1'b0;
      check_ff <= 1'b0;
      if (cmd_fire && is_prog(rev_source))
      begin
        if (op == OP_REV_ON)
          rev_ff <= 1'b1;
        else if (op == OP_REV_OFF)
        begin
          rev_ff <= 1'b0;
          resume_ff <= 1'b1;
          check_ff <= startup_sequence_check;
        end
      end
    end
  end

  // Safety lock and main contactor request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_ff <= 1'b0;
      main_ff <= 1'b0;
    end
    else
    begin
      if (cmd_fire && is_prog(lock_source) && op == OP_LOCK_SET)
        lock_ff <= 1'b1;
      else if (cmd_fire && is_prog(lock_source) && op == OP_LOCK_CLR)
        lock_ff <= 1'b0;
      main_ff <= main_enable && lock_ff;
    end
  end

  // Pump lift contactor, output driver three
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lift_ff <= 1'b0;
    else if (cmd_fire && lift_contactor_allow)
    begin
      if (op == OP_PUMP_ON)
        lift_ff <= 1'b1;
      else if (op == OP_PUMP_OFF)
        lift_ff <= 1'b0;
    end
  end

  // Pot fault thresholds, detection and substitution
  for (genvar p = 0; p < 2; p++)
  begin : g_pot
    wire no_low = (ptype[p] == TYPE_NO_LOW) || (ptype[p] == TYPE_SETUP && onewire[p]);
    wire [8:0] lo_eff = setup_ff[p] ? lo_ff[p] : (no_low ? 9'h000 : POT_LOW_DEF);
    wire [8:0] hi_eff = setup_ff[p] ? hi_ff[p] : POT_HIGH_DEF;
    wire low_chk = setup_ff[p] || !no_low;
    wire fault_now = (low_chk && wiper[p] < lo_eff) || (wiper[p] > hi_eff);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        lo_ff[p] <= POT_LOW_DEF;
        hi_ff[p] <= POT_HIGH_DEF;
        sub_ff[p] <= 15'h0000;
        setup_ff[p] <= 1'b0;
        pfault_ff[p] <= 1'b0;
        pout_ff[p] <= 15'h0000;
      end
      else
      begin
        if (cmd_fire && op == OP_POT_SETUP && sel == 4'(p) && rng_ok)
        begin
          lo_ff[p] <= potarg_ff[8:0];
          hi_ff[p] <= potarg_ff[24:16];
          sub_ff[p] <= subarg_ff[14:0];
          setup_ff[p] <= 1'b1;
        end
        pfault_ff[p] <= fault_now;
        pout_ff[p] <= fault_now ? sub_ff[p] : pval[p];
      end
    end
  end

  // Throttle passes only with the lock set; brake is not gated
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      throttle_out <= 15'h0000;
    else
      throttle_out <= lock_ff ? pout_ff[0] : 15'h0000;
  end

  assign brake_out = pout_ff[1];
  assign pot_fault = pfault_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign precharge_drive = pre_drive_ff;
  assign aux_out_o = aux_o_ff;
  assign aux_out_oe = aux_on_ff;
  assign rescue_reverse_state = rev_ff;
  assign motor_resume = resume_ff;
  assign startup_check_req = check_ff;
  assign main_close_req = main_ff;
  assign lift_driver = lift_ff;
endmodule

// ===== dv/vioc_props.sv
// Checker for the vehicle I/O command logic top.
// Sees only top ports; bound to every vioc_top instance.
module vioc_props #(
  parameter int PRE_LIMIT = 50
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] aux_overcurrent,
  input wire logic [1:0] aux_out_o,
  input wire logic [1:0] aux_out_oe,
  input wire logic precharge_drive,
  input wire logic cap_near_supply,
  input wire logic resistor_energy_over,
  input wire logic rescue_reverse_state,
  input wire logic motor_resume,
  input wire logic startup_check_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Run length of the precharge drive; restarts are never issued mid-run
  logic [31:0] pre_cnt_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !precharge_drive)
      pre_cnt_ff <= 32'h0;
    else
      pre_cnt_ff <= pre_cnt_ff + 32'h1;
  end
  property p_oc_a;
    aux_out_oe[0] && aux_overcurrent[0] |=> !aux_out_oe[0];
  endproperty
  a_oc_a: assert property (p_oc_a) else $error("aux a stayed on in overcurrent");
  property p_oc_b;
    aux_out_oe[1] && aux_overcurrent[1] |=> !aux_out_oe[1];
  endproperty
  a_oc_b: assert property (p_oc_b) else $error("aux b stayed on in overcurrent");
  property p_pin_low;
    aux_out_o == 2'h0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("aux pin driven high");
  property p_pre_stop;
    precharge_drive && (cap_near_supply || resistor_energy_over) |=> !precharge_drive;
  endproperty
  a_pre_stop: assert property (p_pre_stop) else $error("precharge kept on");
  // One cycle for the command, one for the count register
  property p_pre_limit;
    pre_cnt_ff <= PRE_LIMIT + 2;
  endproperty
  a_pre_limit: assert property (p_pre_limit) else $error("precharge over time limit");
  property p_resume_pair;
    startup_check_req |-> motor_resume;
  endproperty
  a_resume_pair: assert property (p_resume_pair) else $error("startup check without resume");
  property p_resume_pulse;
    motor_resume |=> !motor_resume;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("resume longer than a cycle");
  property p_resume_off;
    motor_resume |-> !rescue_reverse_state;
  endproperty
  a_resume_off: assert property (p_resume_off) else $error("resume while reverse on");
  c_pre_end: cover property (precharge_drive ##1 !precharge_drive);
  c_oc: cover property (aux_out_oe[0] && aux_overcurrent[0]);
  c_check: cover property (startup_check_req);
endmodule

bind vioc_top vioc_props #(.PRE_LIMIT(PRE_LIMIT)) vioc_props_i (
  .aclk(aclk),
  .aresetn(aresetn),
  .aux_overcurrent(aux_overcurrent),
  .aux_out_o(aux_out_o),
  .aux_out_oe(aux_out_oe),
  .precharge_drive(precharge_drive),
  .cap_near_supply(cap_near_supply),
  .resistor_energy_over(resistor_energy_over),
  .rescue_reverse_state(rescue_reverse_state),
  .motor_resume(motor_resume),
  .startup_check_req(startup_check_req)
);

// ===== dv/vioc_axi_master.sv
// AXI4-Lite master standing in for the application program.
// Assumes the slave holds its answer until the ready handshake.
module vioc_axi_master (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Payload is inverted once taken, so a stale value is never mistaken for live
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ===== dv/vioc_top_tb.sv
// Self-checking bench for the vehicle I/O command logic.
// Assumes the master model and the bound checker beside the design.
module vioc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vioc_pkg::*;
  localparam int PL = 50;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cap, nrg, pre_drv, rev, resume, chk_req, close_req, lift;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, oc, aux_o, aux_oe, pfault;
  logic [8:0] twip, bwip, lo, hi;
  logic [14:0] tval, bval, tout, bout, sub;
  logic saw_resume = 1'b0;
  int err_count, checks, cyc;
  vioc_top #(.PRE_LIMIT(PL)) vioc_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cap_near_supply(cap), .resistor_energy_over(nrg), .precharge_drive(pre_drv),
    .aux_overcurrent(oc), .aux_out_o(aux_o), .aux_out_oe(aux_oe), .rescue_reverse_state(rev),
    .motor_resume(resume), .startup_check_req(chk_req), .main_close_req(close_req),
    .throttle_wiper(twip), .throttle_value(tval), .brake_wiper(bwip), .brake_value(bval),
    .throttle_out(tout), .brake_out(bout), .pot_fault(pfault), .lift_driver(lift));
  vioc_axi_master vioc_axi_master_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard and sticky capture of a one-cycle resume pulse that comes with a startup check request
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (resume === 1'b1 && chk_req === 1'b1)
      saw_resume <= 1'b1;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    vioc_axi_master_i.rd(a, rd_v, rsp);
    chk($sformatf("reg %h", a), e, rd_v & m);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    vioc_axi_master_i.wr(a, d, rsp);
    chk("bresp", 32'(RESP_OKAY), 32'(rsp));
  endtask
  // Expected result word: return flag in bit 0, error code above it
  task automatic cmd(input logic [3:0] op, input logic [3:0] sel, input logic ret, input logic [7:0] er);
    wrc(VIOC_CMD_OFF, {24'h0, sel, op});
    rdc(VIOC_RESULT_OFF, 32'hFFFF, {16'h0, er, 7'h0, ret});
  endtask
  initial
  begin
    {aresetn, cap, nrg, oc, bval} = '0;
    {err_count, checks} = '0;
    twip = 9'h64;
    bwip = 9'h64;
    tval = 15'h2A5C;
    void'($urandom(32'h0C6B));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(VIOC_STATUS_OFF, 32'hFFFF_FFFF, 32'h0);
    rdc(VIOC_THRLIM_OFF, 32'hFFFF_FFFF, 32'h0160_0006);
    rdc(8'h40, 32'hFFFF_FFFF, 32'h0);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rsp));
    wrc(VIOC_CFG_OFF, 32'h1000);
    cmd(OP_REV_ON, 4'h0, 1'b0, ERR_NONE);
    cmd(OP_LOCK_SET, 4'h0, 1'b0, ERR_NONE);
    cmd(OP_PUMP_ON, 4'h0, 1'b0, ERR_NONE);
    cmd(4'hC, 4'h0, 1'b0, ERR_NONE);
    rdc(VIOC_STATUS_OFF, 32'h3C00, 32'h0);
    wrc(VIOC_CFG_OFF, 32'h1075);
    rdc(VIOC_STATUS_OFF, 32'h2C00, 32'h0);
    cmd(OP_REV_ON, 4'h0, 1'b1, ERR_NONE);
    chk("rev", 32'h1, 32'(rev));
    cmd(OP_REV_OFF, 4'h0, 1'b1, ERR_NONE);
    chk("rev", 32'h0, 32'(rev));
    chk("resume", 32'h1, 32'(saw_resume));
    cmd(OP_PUMP_ON, 4'h0, 1'b1, ERR_NONE);
    chk("lift", 32'h1, 32'(lift));
    cmd(OP_PUMP_OFF, 4'h0, 1'b1, ERR_NONE);
    chk("lift", 32'h0, 32'(lift));
    // Each aux driver: on, trip, re-arm, off
    for (int i = 0; i < 2; i++)
    begin
      cmd(OP_AUX_ON, 4'(i), 1'b1, ERR_NONE);
      chk("oe", 32'(1 << i), 32'(aux_oe));
      @(posedge aclk);
      oc[i] <= 1'b1;
      repeat (3) @(posedge aclk);
      oc[i] <= 1'b0;
      rdc(VIOC_STATUS_OFF, 32'hF0, 32'(1 << (i + 6)));
      cmd(OP_AUX_ON, 4'(i), 1'b1, ERR_NONE);
      rdc(VIOC_STATUS_OFF, 32'hF0, 32'(1 << (i + 4)));
      cmd(OP_AUX_OFF, 4'(i), 1'b1, ERR_NONE);
      chk("oe", 32'h0, 32'(aux_oe));
    end
    cmd(OP_AUX_ON, 4'($urandom_range(2, 15)), 1'b0, INVALID_SELECTOR_ERR);
    cmd(OP_AUX_OFF, 4'hF, 1'b0, INVALID_SELECTOR_ERR);
    // Precharge ends by energy, by supply match, by time limit
    for (int k = 0; k < 3; k++)
    begin
      cmd(OP_PRE_START, 4'h0, 1'b1, ERR_NONE);
      rdc(VIOC_STATUS_OFF, 32'hF, {28'h0, 1'b1, PRE_BUSY});
      @(posedge aclk);
      nrg <= (k == 0);
      cap <= (k == 1);
      repeat (PL + 4) @(posedge aclk);
      rdc(VIOC_STATUS_OFF, 32'hF, k == 0 ? 32'(PRE_ENERGY) : k == 1 ? 32'(PRE_PASSED) : 32'(PRE_TIMEOUT));
      nrg <= 1'b0;
      cap <= 1'b0;
    end
    cmd(OP_PRE_ABORT, 4'h0, 1'b1, ERR_NONE);
    rdc(VIOC_STATUS_OFF, 32'hF, 32'(PRE_ABORTED));
    cmd(OP_LOCK_SET, 4'h0, 1'b1, ERR_NONE);
    chk("close", 32'h1, 32'(close_req));
    // Random thresholds, first pass at the range ends
    for (int j = 0; j < 4; j++)
    begin
      lo = j == 0 ? 9'h0 : 9'($urandom_range(0, 200));
      hi = j == 0 ? POT_MAX : 9'($urandom_range(200, 400));
      sub = 15'($urandom_range(0, 32767));
      wrc(VIOC_POTARG_OFF, {7'h0, hi, 7'h0, lo});
      wrc(VIOC_SUBARG_OFF, {17'h0, sub});
      cmd(OP_POT_SETUP, 4'h0, 1'b1, ERR_NONE);
      rdc(VIOC_THRLIM_OFF, 32'hFFFF_FFFF, {7'h0, hi, 7'h0, lo});
      rdc(VIOC_SUBST_OFF, 32'h7FFF, 32'(sub));
      @(posedge aclk);
      twip <= hi + 9'h1;
      tval <= 15'($urandom);
      repeat (4) @(posedge aclk);
      chk("fault", 32'h1, 32'(pfault[0]));
      chk("tout", 32'(sub), 32'(tout));
      twip <= lo;
      repeat (4) @(posedge aclk);
      chk("tout", 32'(tval), 32'(tout));
    end
    wrc(VIOC_POTARG_OFF, 32'h0191_0000);
    cmd(OP_POT_SETUP, 4'h0, 1'b0, PARAM_RANGE_ERR);
    rdc(VIOC_THRLIM_OFF, 32'hFFFF_FFFF, {7'h0, hi, 7'h0, lo});
    cmd(OP_POT_SETUP, 4'h2, 1'b0, INVALID_SELECTOR_ERR);
    cmd(OP_LOCK_CLR, 4'h0, 1'b1, ERR_NONE);
    repeat (4) @(posedge aclk);
    chk("close", 32'h0, 32'(close_req));
    chk("tout", 32'h0, 32'(tout));
    bwip <= 9'h0;
    bval <= 15'($urandom);
    wrc(VIOC_CFG_OFF, 32'h2075);
    repeat (4) @(posedge aclk);
    chk("brake fault", 32'h0, 32'(pfault[1]));
    chk("bout", 32'(bval), 32'(bout));
    wrc(VIOC_CFG_OFF, 32'h1075);
    repeat (4) @(posedge aclk);
    chk("brake fault", 32'h1, 32'(pfault[1]));
    // Brake substitute was never set up, so the reset value of zero stands in
    chk("bout", 32'h0, 32'(bout));
    conclude();
  end
endmodule
